//--- hw/dma_host_pkg.sv
// Function
// - Descriptors chain through word 0; each holds a packet or one fragment.
// - Start-of-packet flag marks a single-buffer packet or first fragment.
// - End-of-packet flag marks a single-buffer packet or last fragment.
// - Each fragment gets its own descriptor, placed consecutively in the list.
// - Buffer length is valid byte count, or capacity for empty receive buffer.
// - Packet length, total over fragments, matters only in start-of-packet descriptors.
// - After reset, before enabling, write zero to all sixteen head pointers.
// - Device_owns_flag flag lives only in the start-of-packet descriptor and covers the packet.
// - Writing a head pointer starts an idle queue from that descriptor.
// - A zero next pointer is the only end-of-list mark; always terminate lists.
// - Never rewrite a head pointer while its channel's list is active.
// - Zero-terminate a new sublist, then patch the old tail's null next pointer.
// - On end-of-queue with descriptors left, rewrite the head pointer with them.
// - Acknowledge by writing the completion pointer with the device's value.
// - A descriptor is four consecutive aligned 32-bit words.
// - Word 2 holds buffer offset in bits 31:16 and buffer length in 15:0.
package dma_host_pkg;
  localparam int          NUM_CH      = 16;  // Eight transmit then eight receive
  localparam logic [31:0] NULL_PTR    = 32'h0000_0000;
  localparam logic [31:0] OFF_NEXT    = 32'h0000_0000;
  localparam logic [31:0] OFF_FLAGS   = 32'h0000_000c;
  localparam int          F_SOP       = 31;
  localparam int          F_EOP       = 30;
  localparam int          F_OWN       = 29;
  localparam int          F_QEND      = 28;
  // Device register map outside the controller
  localparam logic [31:0] DEV_HEAD_BASE = 32'h0000_0000;
  localparam logic [31:0] DEV_DONE_BASE = 32'h0000_0040;
  // Controller's own command registers
  localparam logic [7:0]  U_DESC      = 8'h00;
  localparam logic [7:0]  U_BUF       = 8'h04;
  localparam logic [7:0]  U_OFFLEN    = 8'h08;
  localparam logic [7:0]  U_LAUNCH    = 8'h0c;
  localparam logic [7:0]  U_STATUS    = 8'h10;
  localparam logic [7:0]  U_ACTIVE    = 8'h14;
  localparam int          L_CH_LSB    = 16;
  localparam logic [3:0]  LAST_CH     = 4'hf;
  localparam logic [1:0]  LAST_WORD   = 2'h3;

  typedef enum logic [3:0] {
    S_INIT, S_IDLE, S_WDESC, S_LINK, S_DECIDE, S_ATTACH,
    S_RDCP, S_RDFLAGS, S_RDNEXT, S_RESTART, S_ACK
  } host_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        dev;    // 1: device register, 0: system memory
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    host_state_t st;
    logic [1:0]  word;
    logic [31:0] desc;
    logic [31:0] bufPtr;
    logic [31:0] offLen;
    logic [31:0] launch;
    logic        go;
    logic        pendV;
    logic [3:0]  pendCh;
    logic [31:0] pendHead;
    logic [31:0] pendTail;
    logic [3:0]  svc;
    logic [31:0] done;
    logic [31:0] nxt;
    logic        refused;
    logic        initDone;
    logic [31:0] rdata;
  } ctx_t;
endpackage : dma_host_pkg

//--- hw/descriptor_queue_host.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module descriptor_queue_host
  import dma_host_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdata,
  output bus_req_t               busReq,
  input  wire logic              busDone,
  input  wire logic [31:0]       busRdata,
  input  wire logic [NUM_CH-1:0] devIrq
);
  ctx_t              c_reg;
  ctx_t              c_next;
  logic [31:0]       tail_reg    [NUM_CH];
  logic [31:0]       tail_next   [NUM_CH];
  logic [31:0]       lastAck_reg [NUM_CH];
  logic [31:0]       lastAck_next[NUM_CH];
  logic [NUM_CH-1:0] active_reg;
  logic [NUM_CH-1:0] active_next;
  logic [3:0]        launchCh;
  logic [3:0]        irqCh;
  logic              irqAny;
  logic [31:0]       chainHead;

  assign launchCh  = c_reg.launch[L_CH_LSB+3:L_CH_LSB];
  // Whole packet goes to the device at once, so it never sees a half-built chain
  assign chainHead = c_reg.pendV ? c_reg.pendHead : c_reg.desc;
  assign regRdata  = c_reg.rdata;

  // Lowest pending channel interrupt wins
  always_comb begin
    irqCh  = 4'h0;
    irqAny = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (devIrq[i]) begin
        irqCh  = i[3:0];
        irqAny = 1'b1;
      end
    end
  end

  // Next-state logic for command registers and the queue walker
  always_comb begin
    c_next       = c_reg;
    tail_next    = tail_reg;
    lastAck_next = lastAck_reg;
    active_next  = active_reg;
    busReq       = '0;
    c_next.rdata = 32'h0000_0000;
    if (regRd) begin
      unique case (regAddr)
        U_DESC:   c_next.rdata = c_reg.desc;
        U_BUF:    c_next.rdata = c_reg.bufPtr;
        U_OFFLEN: c_next.rdata = c_reg.offLen;
        U_LAUNCH: c_next.rdata = c_reg.launch;
        U_STATUS: c_next.rdata = {28'h0, c_reg.refused, c_reg.pendV,
                                  c_reg.initDone, c_reg.go};
        U_ACTIVE: c_next.rdata = {16'h0, active_reg};
        default:  c_next.rdata = 32'h0000_0000;
      endcase
    end
    // Staging stays frozen while a submission is being written out
    if (regWr) begin
      if (regAddr == U_STATUS) begin
        c_next.refused = 1'b0;
      end else if (c_reg.go || !c_reg.initDone) begin
        c_next.refused = 1'b1;
      end else begin
        unique case (regAddr)
          U_DESC:   c_next.desc   = {regWdata[31:2], 2'b00};
          U_BUF:    c_next.bufPtr = regWdata;
          U_OFFLEN: c_next.offLen = regWdata;
          U_LAUNCH: begin
            if (c_reg.pendV && c_reg.pendCh != regWdata[L_CH_LSB+3:L_CH_LSB]) begin
              c_next.refused = 1'b1; // Fragments of one packet stay together
            end else begin
              c_next.launch = regWdata;
              c_next.go     = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
    unique case (c_reg.st)
      // Clear every head pointer before the device is enabled
      S_INIT: begin
        busReq = '{1'b1, 1'b1, 1'b1, DEV_HEAD_BASE + {26'h0, c_reg.svc, 2'b00},
                   NULL_PTR};
        if (busDone) begin
          c_next.svc = c_reg.svc + 4'h1;
          if (c_reg.svc == LAST_CH) begin
            c_next.initDone = 1'b1;
            c_next.st       = S_IDLE;
          end
        end
      end
      S_IDLE: begin
        if (c_reg.go) begin
          c_next.word = 2'h0;
          c_next.st   = S_WDESC;
        end else if (irqAny) begin
          c_next.svc = irqCh;
          c_next.st  = S_RDCP;
        end
      end
      // New descriptor goes out already null-terminated
      S_WDESC: begin
        busReq.valid = 1'b1;
        busReq.write = 1'b1;
        busReq.addr  = c_reg.desc + {28'h0, c_reg.word, 2'b00};
        unique case (c_reg.word)
          2'h0: busReq.wdata = NULL_PTR;
          2'h1: busReq.wdata = c_reg.bufPtr;
          2'h2: busReq.wdata = c_reg.offLen;
          2'h3: busReq.wdata = {c_reg.launch[F_SOP], c_reg.launch[F_EOP],
                                c_reg.launch[F_SOP], 1'b0, 12'h000,
                                c_reg.launch[15:0]};
        endcase
        if (busDone) begin
          c_next.word = c_reg.word + 2'h1;
          if (c_reg.word == LAST_WORD) begin
            c_next.st = c_reg.pendV ? S_LINK : S_DECIDE;
          end
        end
      end
      // Chain this fragment behind the previous one of the same packet
      S_LINK: begin
        busReq = '{1'b1, 1'b1, 1'b0, c_reg.pendTail + OFF_NEXT, c_reg.desc};
        if (busDone) begin
          c_next.st = S_DECIDE;
        end
      end
      S_DECIDE: begin
        if (c_reg.launch[F_EOP]) begin
          c_next.st = S_ATTACH;
        end else begin
          c_next.pendV    = 1'b1;
          c_next.pendCh   = launchCh;
          c_next.pendHead = chainHead;
          c_next.pendTail = c_reg.desc;
          c_next.go       = 1'b0;
          c_next.st       = S_IDLE;
        end
      end
      // Patch the live tail, or start an idle channel through its head pointer
      S_ATTACH: begin
        if (active_reg[launchCh]) begin
          busReq = '{1'b1, 1'b1, 1'b0, tail_reg[launchCh] + OFF_NEXT, chainHead};
        end else begin
          busReq = '{1'b1, 1'b1, 1'b1, DEV_HEAD_BASE + {26'h0, launchCh, 2'b00},
                     chainHead};
        end
        if (busDone) begin
          tail_next[launchCh]   = c_reg.desc;
          active_next[launchCh] = 1'b1;
          c_next.pendV          = 1'b0;
          c_next.go             = 1'b0;
          c_next.st             = S_IDLE;
        end
      end
      S_RDCP: begin
        busReq = '{1'b1, 1'b0, 1'b1, DEV_DONE_BASE + {26'h0, c_reg.svc, 2'b00},
                   32'h0};
        if (busDone) begin
          c_next.done = busRdata;
          // The line lingers a few cycles after an acknowledge; skip repeats
          if (busRdata == NULL_PTR || busRdata == lastAck_reg[c_reg.svc]) begin
            c_next.st = S_IDLE;
          end else begin
            c_next.st = S_RDFLAGS;
          end
        end
      end
      S_RDFLAGS: begin
        busReq = '{1'b1, 1'b0, 1'b0, c_reg.done + OFF_FLAGS, 32'h0};
        if (busDone) begin
          if (!busRdata[F_QEND]) begin
            c_next.st = S_ACK;
          end else if (c_reg.done == tail_reg[c_reg.svc]) begin
            active_next[c_reg.svc] = 1'b0;
            c_next.st              = S_ACK;
          end else begin
            c_next.st = S_RDNEXT;
          end
        end
      end
      // Device stopped before seeing the patch: fetch what it missed
      S_RDNEXT: begin
        busReq = '{1'b1, 1'b0, 1'b0, c_reg.done + OFF_NEXT, 32'h0};
        if (busDone) begin
          c_next.nxt = busRdata;
          if (busRdata == NULL_PTR) begin
            active_next[c_reg.svc] = 1'b0;
            c_next.st              = S_ACK;
          end else begin
            c_next.st = S_RESTART;
          end
        end
      end
      S_RESTART: begin
        busReq = '{1'b1, 1'b1, 1'b1, DEV_HEAD_BASE + {26'h0, c_reg.svc, 2'b00},
                   c_reg.nxt};
        if (busDone) begin
          c_next.st = S_ACK;
        end
      end
      // Acknowledge with exactly the value the device reported
      S_ACK: begin
        busReq = '{1'b1, 1'b1, 1'b1, DEV_DONE_BASE + {26'h0, c_reg.svc, 2'b00},
                   c_reg.done};
        if (busDone) begin
          lastAck_next[c_reg.svc] = c_reg.done;
          c_next.st               = S_IDLE;
        end
      end
      default: c_next.st = S_IDLE;
    endcase
  end

  // State registers; clock enable freezes everything
  always_ff @(posedge core_clk) begin
    if (rst) begin
      c_reg      <= '0;
      active_reg <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        tail_reg[i]    <= NULL_PTR;
        lastAck_reg[i] <= NULL_PTR;
      end
    end else if (ce) begin
      c_reg       <= c_next;
      active_reg  <= active_next;
      tail_reg    <= tail_next;
      lastAck_reg <= lastAck_next;
    end
  end
endmodule : descriptor_queue_host
`default_nettype wire

//--- verification/queue_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module queue_host_properties
  import dma_host_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic [7:0]        regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  input wire bus_req_t          busReq,
  input wire logic              busDone,
  input wire logic [31:0]       busRdata,
  input wire logic [NUM_CH-1:0] devIrq
);
  wire logic   doneAcc = busReq.valid && busReq.dev && busReq.addr >= DEV_DONE_BASE;
  logic [31:0] doneSeen_reg;
  logic [31:0] doneSeen_next;
  // Keep the pointer last read back, since an ack must echo exactly that
  always_comb begin
    doneSeen_next = doneSeen_reg;
    if (busDone && doneAcc && !busReq.write) doneSeen_next = busRdata;
  end
  always_ff @(posedge core_clk) doneSeen_reg <= rst ? 32'h0 : doneSeen_next;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Flags word of a descriptor going out to memory
  sequence flagsWr;
    busReq.valid && busReq.write && !busReq.dev && busReq.addr[3:0] == 4'hc;
  endsequence
  a_init_first: assert property ($fell(rst) |-> busReq.valid && busReq.dev
    && busReq.write && busReq.addr == DEV_HEAD_BASE && busReq.wdata == NULL_PTR)
    else $error("first request is not a zero head write");
  a_req_held: assert property (busReq.valid && !busDone |=> $stable(busReq))
    else $error("request changed before its answer");
  a_word_align: assert property (busReq.valid |-> busReq.addr[1:0] == 2'h0)
    else $error("unaligned bus address");
  a_reg_range: assert property (busReq.valid && busReq.dev |->
    busReq.addr < DEV_DONE_BASE + 32'h40) else $error("device address out of range");
  a_device_owns_flag_sop: assert property (flagsWr |-> busReq.wdata[F_OWN] == busReq.wdata[F_SOP])
    else $error("device_owns_flag flag not tied to start flag");
  a_flags_clean: assert property (flagsWr |-> !busReq.wdata[F_QEND]
    && busReq.wdata[27:16] == 12'h0) else $error("flags word carries stray bits");
  a_ack_echo: assert property (doneAcc && busReq.write |-> busReq.wdata == doneSeen_reg)
    else $error("ack value differs from read pointer");
  a_rdata_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its slot");
endmodule : queue_host_properties
bind descriptor_queue_host queue_host_properties queue_host_properties_inst (.core_clk,
  .rst, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .busReq, .busDone,
  .busRdata, .devIrq);
`default_nettype wire

//--- verification/dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dev_model
  import dma_host_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire bus_req_t          busReq,
  output logic                   busDone,
  output logic      [31:0]       busRdata,
  output logic      [NUM_CH-1:0] devIrq
);
  logic [31:0]       mem     [0:255];
  logic [31:0]       headPtr [0:NUM_CH-1];
  logic [31:0]       donePtr [0:NUM_CH-1];
  logic [NUM_CH-1:0] irqRaw;
  logic [NUM_CH-1:0] irqMask;
  logic [1:0]        wait_reg;
  logic [1:0]        lat_reg;
  logic [31:0]       d;
  logic [31:0]       pktStart;
  logic [3:0]        ch;
  // Only enabled channels reach the pins
  assign devIrq = irqRaw & irqMask;
  // Answers alternate prompt and slow; up to 64 descriptors of the list are walked at the head write
  always @(posedge core_clk) begin
    ch = busReq.addr[5:2];
    if (rst) begin
      busDone <= 1'b0;
      busRdata <= 32'h0;
      wait_reg <= 2'h0;
      lat_reg <= 2'h0;
      irqRaw <= '0;
      irqMask <= '1;  // Host enables every channel; the controller leaves masks alone
      for (int i = 0; i < NUM_CH; i++) headPtr[i] <= 32'hffff_ffff;
      for (int i = 0; i < NUM_CH; i++) donePtr[i] <= 32'h0;
    end else if (busDone || !busReq.valid) begin
      busDone <= 1'b0;
      busRdata <= ~busRdata;  // Released bus inverts its last word every cycle
    end else if (wait_reg != lat_reg) begin
      wait_reg <= wait_reg + 2'h1;
    end else begin
      busDone <= 1'b1;
      wait_reg <= 2'h0;
      lat_reg <= lat_reg ^ 2'h2;
      if (!busReq.dev && busReq.write) mem[busReq.addr[9:2]] = busReq.wdata;
      else if (!busReq.dev) busRdata <= mem[busReq.addr[9:2]];
      else if (busReq.addr >= DEV_DONE_BASE && !busReq.write) busRdata <= donePtr[ch];
      else if (busReq.addr >= DEV_DONE_BASE && busReq.wdata == donePtr[ch]) begin
        irqRaw[ch] <= 1'b0;
      end else if (busReq.addr < DEV_DONE_BASE) begin
        headPtr[ch] <= busReq.wdata;
        d = busReq.wdata;
        for (int i = 0; i < 64 && d != NULL_PTR; i++) begin
          if (mem[d[9:2] + 3][F_SOP]) pktStart = d;
          if (mem[d[9:2] + 3][F_EOP]) begin
            mem[pktStart[9:2] + 3][F_OWN] = 1'b0;
            mem[d[9:2] + 3][F_QEND] = mem[d[9:2]] == NULL_PTR;
            donePtr[ch] <= d;
            irqRaw[ch] <= 1'b1;
          end
          d = mem[d[9:2]];
        end
      end
    end
  end
endmodule : dev_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dma_host_pkg::*;
;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic              ce = 1'b1;
  logic [7:0]        regAddr = 8'h00;
  logic [31:0]       regWdata = 32'h0;
  logic [31:0]       regRdata, busRdata, v, a;
  logic              busDone;
  logic [NUM_CH-1:0] devIrq;
  bus_req_t          busReq;
  int                fails = 0, comparisons = 0, cycles = 0;
  descriptor_queue_host descriptor_queue_host_inst (.core_clk, .rst, .ce, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .busReq, .busDone, .busRdata, .devIrq);
  dev_model dev_model_inst (.core_clk, .rst, .busReq, .busDone, .busRdata, .devIrq);
  initial forever #2 core_clk = ~core_clk;
  // Cut a hang short well beyond the expected thousand or so cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  function automatic logic [31:0] mw(input logic [31:0] ad);
    return dev_model_inst.mem[ad[9:2]];
  endfunction : mw
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge core_clk);
    regAddr <= ad;
    regWdata <= dt;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge core_clk);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 dt = regRdata;
  endtask : rd
  // Poll a register under a bound until the masked value shows up
  task automatic waitFor(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] w);
    logic [31:0] dt;
    int          n = 0;
    do begin
      rd(ad, dt);
      n++;
    end while ((dt & m) !== w && n < 300);
    chk(dt & m, w);
  endtask : waitFor
  task automatic submit(input logic [31:0] desc, input logic [31:0] ctl);
    wr(U_DESC, desc);
    wr(U_BUF, desc + 32'h1000);
    wr(U_OFFLEN, {16'h0004, ctl[15:0]});
    wr(U_LAUNCH, ctl);
    waitFor(U_STATUS, 32'h1, 32'h0);
    for (int n = 0; n < 99 && devIrq !== '0; n++) @(posedge core_clk);
  endtask : submit
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    wr(U_LAUNCH, 32'hc000_0010);  // Too early, must be refused
    waitFor(U_STATUS, 32'ha, 32'ha);
    for (int i = 0; i < NUM_CH; i++) chk(dev_model_inst.headPtr[i], NULL_PTR);
    wr(U_STATUS, 32'h0);
    rd(8'h20, v);
    chk(v, 32'h0);  // Unmapped address reads zero
    // Clock enable low must swallow a launch whole
    @(posedge core_clk);
    ce <= 1'b0;
    wr(U_LAUNCH, 32'hc000_0010);
    ce <= 1'b1;
    rd(U_STATUS, v);
    chk(v, 32'h0000_0002);
    // One whole packet on every channel, tx then rx
    for (int c = 0; c < NUM_CH; c++) begin
      a = 32'h100 + 32'(c) * 32'h10;
      submit(a, {2'b11, 10'h0, 4'(c), 16'h0040 + 16'(c)});
      chk(mw(a + 12), {4'b1101, 12'h0, 16'h0040 + 16'(c)});
      chk(mw(a), NULL_PTR);
      chk(mw(a + 8), {16'h0004, 16'h0040 + 16'(c)});
      chk(dev_model_inst.donePtr[c], a);
      chk(32'(devIrq), 32'h0);
      rd(U_ACTIVE, v);
      chk(v, 32'h0);
    end
    // Fragmented packet held back, other channel refused meanwhile
    submit(32'h300, {2'b10, 10'h0, 4'h9, 16'h0100});
    wr(U_LAUNCH, {2'b11, 10'h0, 4'h3, 16'h0010});
    waitFor(U_STATUS, 32'hd, 32'hc);
    // Channel 9 head still holds its earlier single packet, not the held fragment
    chk(dev_model_inst.headPtr[9], 32'h0000_0190);
    wr(U_STATUS, 32'h0);
    submit(32'h310, {2'b01, 10'h0, 4'h9, 16'h0080});
    chk(mw(32'h300), 32'h310);
    chk(mw(32'h30c), {4'b1000, 12'h0, 16'h0100});
    chk(mw(32'h31c), {4'b0101, 12'h0, 16'h0080});
    chk(dev_model_inst.donePtr[9], 32'h310);
    conclude();
  end
endmodule : testbench
`default_nettype wire
